// ---- irc_pkg.sv ----
// Package with register map, field layout, reset values and range codes of the input range bank.
package irc_pkg;

  // Register indices as printed; byte address is four times the index.
  localparam logic [6:0]  IRC_IDX_GRP_A_UPPER = 7'h05;
  localparam logic [6:0]  IRC_IDX_GRP_B_LOWER = 7'h06;
  localparam logic [7:0]  IRC_ADDR_GRP_A_UPPER = 8'h14;
  localparam logic [7:0]  IRC_ADDR_GRP_B_LOWER = 8'h18;

  // Word layout.
  localparam int          IRC_ADDR_FIELD_LSB  = 9;
  localparam int          IRC_ADDR_FIELD_MSB  = 15;
  localparam int          IRC_RSVD_BIT        = 8;
  localparam int          IRC_FIELD_W         = 2;
  localparam int          IRC_FIELDS          = 4;
  localparam int          IRC_REG_W           = 16;

  // Reset value of each range register word and of each range field.
  localparam logic [15:0] IRC_RESET_WORD      = 16'h00ff;
  localparam logic [1:0]  IRC_RESET_FIELD     = 2'h3;

  // Range field encodings.
  localparam logic [1:0]  IRC_CODE_10V_A      = 2'h0;
  localparam logic [1:0]  IRC_CODE_2V5        = 2'h1;
  localparam logic [1:0]  IRC_CODE_5V         = 2'h2;
  localparam logic [1:0]  IRC_CODE_10V_B      = 2'h3;

  // Decoded range, one-hot.
  typedef enum logic [2:0] {
    IRC_RANGE_10V  = 3'h1,
    IRC_RANGE_5V   = 3'h2,
    IRC_RANGE_2V5  = 3'h4
  } irc_range_e;

  // AXI4-Lite responses.
  localparam logic [1:0]  IRC_RESP_OKAY       = 2'h0;
  localparam logic [1:0]  IRC_RESP_SLVERR     = 2'h2;

  // Bus transaction states.
  typedef enum logic [2:0] {
    IRC_ST_IDLE = 3'h1,
    IRC_ST_BRSP = 3'h2,
    IRC_ST_RRSP = 3'h4
  } irc_state_e;

endpackage

// ---- irc_range_decode.sv ----
// Module that decodes one 2-bit range field into a one-hot range selection.
`timescale 1ns/1ps
module irc_range_decode
  import irc_pkg::*;
(
  input  wire logic [1:0] fieldCode,
  output irc_range_e      rangeSel
);

  // Both 00 and 11 select the widest range.
  always_comb begin
    case (fieldCode)
      IRC_CODE_2V5: rangeSel = IRC_RANGE_2V5;
      IRC_CODE_5V:  rangeSel = IRC_RANGE_5V;
      default:      rangeSel = IRC_RANGE_10V;
    endcase
  end

endmodule

// ---- irc_input_range_regs.sv ----
// Top module: AXI4-Lite slave holding the two input range registers and their decoded ranges.
//
// Function
// - Group A ch4-7 register at 0x05, resets 0x00FF.
// - Group B ch0-3 register at 0x06, resets 0x00FF.
// - Bits 15:9 address field, bit 8 reserved.
// - Group A fields map channels seven down to four.
// - Group B fields map channels three down to zero.
// - Codes: 00/11 10V, 01 2.5V, 10 5V.
// - Every range field resets to 0x3.
// - All bits read back last written value.
`timescale 1ns/1ps
module irc_input_range_regs
  import irc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [1:0]       range_grp_a_ch7,
  output logic [1:0]       range_grp_a_ch6,
  output logic [1:0]       range_grp_a_ch5,
  output logic [1:0]       range_grp_a_ch4,
  output logic [1:0]       range_grp_b_ch3,
  output logic [1:0]       range_grp_b_ch2,
  output logic [1:0]       range_grp_b_ch1,
  output logic [1:0]       range_grp_b_ch0,
  output logic [2:0]       rangeSelA [IRC_FIELDS],
  output logic [2:0]       rangeSelB [IRC_FIELDS]
);

  // Whole state of the block, apart from the reset synchronizer flops, in one record.
  typedef struct packed {
    irc_state_e  state;
    logic        awHeld;
    logic [7:0]  awAddr;
    logic        wHeld;
    logic [15:0] wData;
    logic [1:0]  wStrb;
    logic        awReady;
    logic        wReady;
    logic        arReady;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [1:0]  rResp;
    logic [15:0] rData;
    logic [15:0] regA;
    logic [15:0] regB;
    logic [23:0] rangeSel;
  } irc_state_s;

  irc_state_s stReg;
  irc_state_s stNext;
  logic       rstMeta;
  logic       rstSync_n;
  irc_range_e decA [IRC_FIELDS];
  irc_range_e decB [IRC_FIELDS];

  // Reset release through two flip-flops.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta   <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta   <= 1'b1;
      rstSync_n <= rstMeta;
    end
  end

  // One decoder per channel field of each register.
  for (genvar i = 0; i < IRC_FIELDS; i++) begin : gDec
    irc_range_decode uDecA (
      .fieldCode (stReg.regA[i*IRC_FIELD_W +: IRC_FIELD_W]),
      .rangeSel  (decA[i])
    );
    irc_range_decode uDecB (
      .fieldCode (stReg.regB[i*IRC_FIELD_W +: IRC_FIELD_W]),
      .rangeSel  (decB[i])
    );
  end

  // Next-state logic: accept address and data in either order, then answer.
  always_comb begin
    logic [15:0] merged;
    logic [15:0] cur;
    merged = '0;
    cur    = '0;
    stNext = stReg;
    if (s_axi_awvalid && stReg.awReady) begin
      stNext.awHeld  = 1'b1;
      stNext.awAddr  = s_axi_awaddr;
      stNext.awReady = 1'b0;
    end
    if (s_axi_wvalid && stReg.wReady) begin
      stNext.wHeld  = 1'b1;
      stNext.wData  = s_axi_wdata[15:0];
      stNext.wStrb  = s_axi_wstrb[1:0];
      stNext.wReady = 1'b0;
    end
    case (stReg.state)
      IRC_ST_IDLE: begin
        if (stReg.awHeld && stReg.wHeld) begin
          // Byte lanes merge into the held word; unmapped addresses get an error.
          cur = (stReg.awAddr[7:2] == IRC_ADDR_GRP_A_UPPER[7:2]) ? stReg.regA : stReg.regB;
          merged[7:0]  = stReg.wStrb[0] ? stReg.wData[7:0]  : cur[7:0];
          merged[15:8] = stReg.wStrb[1] ? stReg.wData[15:8] : cur[15:8];
          stNext.bResp = IRC_RESP_OKAY;
          if (stReg.awAddr[7:2] == IRC_ADDR_GRP_A_UPPER[7:2]) begin
            stNext.regA = merged;
          end else if (stReg.awAddr[7:2] == IRC_ADDR_GRP_B_LOWER[7:2]) begin
            stNext.regB = merged;
          end else begin
            stNext.bResp = IRC_RESP_SLVERR;
          end
          stNext.awHeld = 1'b0;
          stNext.wHeld  = 1'b0;
          stNext.bValid = 1'b1;
          stNext.state  = IRC_ST_BRSP;
        end else if (s_axi_arvalid && stReg.arReady) begin
          stNext.arReady = 1'b0;
          stNext.rValid  = 1'b1;
          stNext.rResp   = IRC_RESP_OKAY;
          if (s_axi_araddr[7:2] == IRC_ADDR_GRP_A_UPPER[7:2]) begin
            stNext.rData = stReg.regA;
          end else if (s_axi_araddr[7:2] == IRC_ADDR_GRP_B_LOWER[7:2]) begin
            stNext.rData = stReg.regB;
          end else begin
            stNext.rData = '0;
            stNext.rResp = IRC_RESP_SLVERR;
          end
          stNext.state = IRC_ST_RRSP;
        end
      end
      IRC_ST_BRSP: begin
        if (s_axi_bready) begin
          stNext.bValid  = 1'b0;
          stNext.awReady = 1'b1;
          stNext.wReady  = 1'b1;
          stNext.state   = IRC_ST_IDLE;
        end
      end
      IRC_ST_RRSP: begin
        if (s_axi_rready) begin
          stNext.rValid  = 1'b0;
          stNext.arReady = 1'b1;
          stNext.state   = IRC_ST_IDLE;
        end
      end
      default: begin
        stNext.state = IRC_ST_IDLE;
      end
    endcase
    // Offer a read only when the next edge can take it, so a read handshake is never dropped.
    stNext.arReady = (stNext.state == IRC_ST_IDLE) && !(stNext.awHeld && stNext.wHeld);
    // Decoded ranges follow the stored fields one cycle after the write lands.
    for (int i = 0; i < IRC_FIELDS; i++) begin
      stNext.rangeSel[i*3 +: 3]      = decA[i];
      stNext.rangeSel[12 + i*3 +: 3] = decB[i];
    end
  end

  // State register with reset values.
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      stReg          <= '0;
      stReg.state    <= IRC_ST_IDLE;
      stReg.awReady  <= 1'b1;
      stReg.wReady   <= 1'b1;
      stReg.arReady  <= 1'b1;
      stReg.regA     <= IRC_RESET_WORD;
      stReg.regB     <= IRC_RESET_WORD;
      stReg.rangeSel <= {8{IRC_RANGE_10V}};
    end else begin
      stReg <= stNext;
    end
  end

  // Outputs straight from the state record.
  assign s_axi_awready   = stReg.awReady;
  assign s_axi_wready    = stReg.wReady;
  assign s_axi_bvalid    = stReg.bValid;
  assign s_axi_bresp     = stReg.bResp;
  assign s_axi_arready   = stReg.arReady;
  assign s_axi_rvalid    = stReg.rValid;
  assign s_axi_rresp     = stReg.rResp;
  assign s_axi_rdata     = {16'h0000, stReg.rData};
  assign range_grp_a_ch7 = stReg.regA[7:6];
  assign range_grp_a_ch6 = stReg.regA[5:4];
  assign range_grp_a_ch5 = stReg.regA[3:2];
  assign range_grp_a_ch4 = stReg.regA[1:0];
  assign range_grp_b_ch3 = stReg.regB[7:6];
  assign range_grp_b_ch2 = stReg.regB[5:4];
  assign range_grp_b_ch1 = stReg.regB[3:2];
  assign range_grp_b_ch0 = stReg.regB[1:0];
  for (genvar i = 0; i < IRC_FIELDS; i++) begin : gSel
    assign rangeSelA[i] = stReg.rangeSel[i*3 +: 3];
    assign rangeSelB[i] = stReg.rangeSel[12 + i*3 +: 3];
  end

  // Checks next to the logic.
  chk_reset_value_a: assert property (@(posedge clk_sys) $rose(rstSync_n) |-> stReg.regA == 16'h00ff)
    else $error("Group A register did not reset to 00ff.");
  chk_reset_value_b: assert property (@(posedge clk_sys) $rose(rstSync_n) |-> stReg.regB == 16'h00ff)
    else $error("Group B register did not reset to 00ff.");
  chk_reset_fields: assert property (@(posedge clk_sys) $rose(rstSync_n) |->
    range_grp_b_ch0 == 2'h3 && range_grp_a_ch7 == 2'h3)
    else $error("Range field did not reset to 3.");
  chk_write_a_store: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    stReg.state == IRC_ST_IDLE && stReg.awHeld && stReg.wHeld && stReg.awAddr == 8'h14 && stReg.wStrb == 2'h3
    |=> stReg.regA == $past(stReg.wData))
    else $error("Write to group A register not stored.");
  chk_write_b_store: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    stReg.state == IRC_ST_IDLE && stReg.awHeld && stReg.wHeld && stReg.awAddr == 8'h18 && stReg.wStrb == 2'h3
    |=> stReg.regB == $past(stReg.wData) && stReg.bResp == 2'h0)
    else $error("Write to group B register not stored.");
  chk_read_back_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    stReg.state == IRC_ST_IDLE && !(stReg.awHeld && stReg.wHeld) &&
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h14
    |=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(stReg.regA)})
    else $error("Read of group A register returned wrong word.");
  chk_decode_range: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    range_grp_a_ch5 == 2'h1 ##1 range_grp_a_ch5 == 2'h1 |-> rangeSelA[1] == 3'h4)
    else $error("Code 01 did not select the 2.5 V range.");
  chk_decode_fiveV: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    range_grp_b_ch3 == 2'h2 ##1 range_grp_b_ch3 == 2'h2 |-> rangeSelB[3] == 3'h2)
    else $error("Code 10 did not select the 5 V range.");
  chk_range_lag: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    $changed(range_grp_a_ch4) |=> rangeSelA[0] == (($past(range_grp_a_ch4) == 2'h1) ? 3'h4 :
                                                   ($past(range_grp_a_ch4) == 2'h2) ? 3'h2 : 3'h1))
    else $error("Decoded range not updated after write.");

endmodule

// ---- irc_host_model.sv ----
// Host model that issues register writes and reads over AXI4-Lite.
`timescale 1ns/1ps
module irc_host_model
  import irc_pkg::*;
(
  input  wire logic        clk_sys,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // The bus is idle at time zero.
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // Writes one word; released address and data lines show the inverse so stale values never look valid.
  task automatic wrWord(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s, output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk_sys);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~{16'h0000, d};
      end
    end
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Reads one word and holds rready until the answer is sampled.
  task automatic rdWord(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr  <= ~a;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ---- irc_input_range_regs_tb.sv ----
// Testbench for the input range register bank.
`timescale 1ns/1ps
module irc_input_range_regs_tb
  import irc_pkg::*;
;
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
  } irc_row_s;

  logic        clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdData;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [1:0]  range_grp_a_ch7, range_grp_a_ch6, range_grp_a_ch5, range_grp_a_ch4;
  logic [1:0]  range_grp_b_ch3, range_grp_b_ch2, range_grp_b_ch1, range_grp_b_ch0;
  logic [2:0]  rangeSelA [IRC_FIELDS];
  logic [2:0]  rangeSelB [IRC_FIELDS];
  int          errCount = 0;
  int          nCompared = 0;
  int          cycles = 0;
  // The first two rows carry their own register index in bits 15:9; together the rows use every range code.
  irc_row_s    rows [4] = '{'{IRC_ADDR_GRP_A_UPPER, 16'h0b1b}, '{IRC_ADDR_GRP_B_LOWER, 16'h0ce4},
                            '{IRC_ADDR_GRP_A_UPPER, 16'h00e4}, '{IRC_ADDR_GRP_B_LOWER, 16'hff1b}};

  irc_input_range_regs dut_u (.*);
  irc_host_model host_u (.*);

  // Free-running clock at 125 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Cuts a hang short.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errCount++;
      completeRun();
    end
  end

  // Compares one value and counts it.
  task automatic cmpVal(input string nm, input logic [31:0] e, input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      errCount++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Expected one-hot range for a field code.
  function automatic logic [2:0] ohot(input logic [1:0] c);
    return (c == IRC_CODE_2V5) ? 3'h4 : (c == IRC_CODE_5V) ? 3'h2 : 3'h1;
  endfunction

  // Checks the field outputs and decoded ranges of one group.
  task automatic chkPorts(input logic [7:0] a, input logic [7:0] f);
    logic [7:0] got;
    logic [2:0] sel [IRC_FIELDS];
    if (a == IRC_ADDR_GRP_A_UPPER) begin
      got = {range_grp_a_ch7, range_grp_a_ch6, range_grp_a_ch5, range_grp_a_ch4};
      sel = rangeSelA;
    end else begin
      got = {range_grp_b_ch3, range_grp_b_ch2, range_grp_b_ch1, range_grp_b_ch0};
      sel = rangeSelB;
    end
    cmpVal("range fields", {24'h0, f}, {24'h0, got});
    for (int i = 0; i < IRC_FIELDS; i++) begin
      cmpVal("decoded range", {29'h0, ohot(f[2*i +: 2])}, {29'h0, sel[i]});
    end
  endtask

  // Resets, then checks reset values at the addresses of the first two rows.
  task automatic resetAndCheck();
    rst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (rows[k]) begin
      if (k < 2) begin
        host_u.rdWord(rows[k].addr, rdData, resp);
        cmpVal("reset word", {16'h0, IRC_RESET_WORD}, rdData);
        chkPorts(rows[k].addr, IRC_RESET_WORD[7:0]);
      end
    end
    $display("Test reset values done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic completeRun();
    $display("Compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    resetAndCheck();
    foreach (rows[k]) begin
      host_u.wrWord(rows[k].addr, rows[k].data, 4'h3, resp);
      cmpVal("write resp", {30'h0, IRC_RESP_OKAY}, {30'h0, resp});
      host_u.rdWord(rows[k].addr, rdData, resp);
      cmpVal("read word", {16'h0, rows[k].data}, rdData);
      chkPorts(rows[k].addr, rows[k].data[7:0]);
    end
    $display("Test row table done");
    host_u.wrWord(8'h1c, 16'hffff, 4'h3, resp);
    cmpVal("unmapped write resp", {30'h0, IRC_RESP_SLVERR}, {30'h0, resp});
    host_u.rdWord(8'h1c, rdData, resp);
    cmpVal("unmapped read resp", {30'h0, IRC_RESP_SLVERR}, {30'h0, resp});
    cmpVal("unmapped read data", 32'h00000000, rdData);
    host_u.rdWord(IRC_ADDR_GRP_A_UPPER, rdData, resp);
    cmpVal("group a kept", 32'h000000e4, rdData);
    host_u.wrWord(IRC_ADDR_GRP_B_LOWER, 16'h5aa4, 4'h1, resp);
    cmpVal("strobe write resp", {30'h0, IRC_RESP_OKAY}, {30'h0, resp});
    host_u.rdWord(IRC_ADDR_GRP_B_LOWER, rdData, resp);
    cmpVal("byte strobe word", 32'h0000ffa4, rdData);
    chkPorts(IRC_ADDR_GRP_B_LOWER, 8'ha4);
    $display("Test unmapped and strobe done");
    resetAndCheck();
    completeRun();
  end
endmodule
